/* include/dmabs_pkg.sv */
// Package: constants and types for the DMA bus-master sequencer
package dmabs_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CHANNELS     = 8;
  localparam int CHAN_BITS    = 3;
  localparam int ADDR_BITS    = 32;
  localparam int COUNT_BITS   = 24;
  localparam int HOLD_BITS    = 32;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [2:0]  ACK_IDLE_CODE = 3'h4;
  localparam logic [31:0] ADDR_RESET    = 32'h00000000;
  localparam logic [23:0] COUNT_RESET   = 24'h000000;

  // ----------------------------------------
  // Address step modes and widths
  // ----------------------------------------
  typedef enum logic [1:0] {
    DMABS_STEP_INC  = 2'b00,
    DMABS_STEP_DEC  = 2'b01,
    DMABS_STEP_HOLD = 2'b10
  } dmabs_step_type;

  typedef enum logic [1:0] {
    DMABS_W_BYTE = 2'b00,
    DMABS_W_HALF = 2'b01,
    DMABS_W_WORD = 2'b10
  } dmabs_width_type;

  // ----------------------------------------
  // Bus states
  // ----------------------------------------
  typedef enum logic [2:0] {
    DMABS_IDLE       = 3'b000,
    DMABS_ADDRESS    = 3'b001,
    DMABS_DATA       = 3'b010,
    DMABS_PIPE_ADDR  = 3'b011,
    DMABS_PIPE_DATA  = 3'b100,
    DMABS_PIPE_WAIT  = 3'b101
  } dmabs_bus_type;

endpackage : dmabs_pkg

/* src/dmabs_sequencer.sv */
// Module: DMA bus-master sequencer with channel address and count state
//
// Behaviour
// R1 - Master bus goes idle after reset, when no address ready, or process ends
// R2 - Unpipelined cycle starts in address state, always followed by data state
// R3 - Data state repeats without acknowledge while next-address request inactive
// R4 - Acknowledged data goes to address state if address ready, else idle
// R5 - Pipe-data follows pipe-address or data on next-address; drives next address
// R6 - First cycle after idle unpipelined; pipelining needs request and pipe-data end
// R7 - Unacknowledged pipelined cycle is lengthened with more pipe-data states
// R8 - Data with request, no acknowledge, no address enters pipe-wait and stays
// R9 - Pipe-address with request waits in pipe-wait until next address ready
// R10 - Finished process enters pipe-wait from data or pipe-address to end cycle
// R11 - Slave mode watches strobe and acknowledge; pipelined decode one state early
// R12 - Acknowledge sampled at end of every data and pipe-data state
// R13 - Eight independent channels
// R14 - Any memory and I/O mix, byte, halfword and word widths
// R15 - Base and current addresses; current steps inc/dec/hold, base never changes
// R16 - Count drops per byte; past zero gives terminal count, end or restart
// R17 - Per-channel 32-bit holding register kept across interruption
// R18 - Slave until software or hardware request; host reaches registers meanwhile
// R19 - Service request raises hold; master only after hold acknowledge
// R20 - Channel chosen by priority at moment of mastership
// R21 - Bus kept until hold acknowledge drops or transfer finishes
// R22 - On completion drop hold, return to slave, re-raise if requests remain
// R23 - One bus state lasts two input clock periods
// R24 - Bus driving begins one state after hold acknowledge goes active
// R25 - Next-address request active low, ignored in slave mode
// R26 - Address-available flag drives transitions depending on address readiness
`timescale 1ns/1ps

module dmabs_sequencer #(
  parameter int CHANNELS   = dmabs_pkg::CHANNELS,
  parameter int COUNT_BITS = dmabs_pkg::COUNT_BITS
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic                          CLK_EN,
  // Channel setup (host side while slave)
  input  wire logic                          SETUP_WE,
  input  wire logic [dmabs_pkg::CHAN_BITS-1:0] SETUP_CHAN,
  input  wire logic [31:0]                   SETUP_REQ_BASE,
  input  wire logic [31:0]                   SETUP_TGT_BASE,
  input  wire logic [COUNT_BITS-1:0]         SETUP_COUNT,
  input  wire logic [1:0]                    SETUP_REQ_STEP,
  input  wire logic [1:0]                    SETUP_TGT_STEP,
  input  wire logic [1:0]                    SETUP_WIDTH,
  input  wire logic                          SETUP_AUTOINIT,
  input  wire logic [CHANNELS-1:0]           SW_REQUEST,
  input  wire logic [CHANNELS-1:0]           CHANNEL_REQUEST,
  // Host handover
  input  wire logic                          HOLD_ACK,
  output logic                               HOLD_REQ,
  // Local bus
  input  wire logic                          READY_N,
  input  wire logic                          NEXT_ADDRESS_REQUEST_N,
  input  wire logic                          ADDRESS_STROBE_N,
  input  wire logic                          END_OF_PROCESS_N,
  input  wire logic [31:0]                   DATA_IN,
  output logic [31:0]                        ADDR_OUT,
  output logic                               ADDR_OE,
  output logic                               ADDRESS_STROBE_OUT_N,
  output logic                               TARGET_PHASE,
  output logic [2:0]                         ACK_CODE,
  output logic [31:0]                        HOLDING_OUT,
  output logic [CHANNELS-1:0]                TERMINAL_COUNT,
  output logic                               SLAVE_DECODE,
  output logic [2:0]                         BUS_STATE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic                     phase, next_phase;
  logic                     master, next_master;
  logic                     granted, next_granted;
  dmabs_pkg::dmabs_bus_type bstate, next_bstate;
  logic [2:0]               chan, next_chan;
  logic                     tgt_side, next_tgt_side;
  logic                     address_available, next_address_available;
  logic                     hold_q, next_hold_q;
  logic                     sl_pipe, next_sl_pipe;
  logic                     sl_dec, next_sl_dec;
  logic                     sl_ack_prev, next_sl_ack_prev;
  logic [31:0]              req_base [CHANNELS], req_cur [CHANNELS];
  logic [31:0]              tgt_base [CHANNELS], tgt_cur [CHANNELS];
  logic [31:0]              hold_reg [CHANNELS];
  logic [COUNT_BITS-1:0]    cnt_base [CHANNELS], cnt_cur [CHANNELS];
  logic [1:0]               rstep [CHANNELS], tstep [CHANNELS], wid [CHANNELS];
  logic [CHANNELS-1:0]      autoi, pend, tc;
  logic [31:0]              next_req_base [CHANNELS], next_req_cur [CHANNELS];
  logic [31:0]              next_tgt_base [CHANNELS], next_tgt_cur [CHANNELS];
  logic [31:0]              next_hold_reg [CHANNELS];
  logic [COUNT_BITS-1:0]    next_cnt_base [CHANNELS], next_cnt_cur [CHANNELS];
  logic [1:0]               next_rstep [CHANNELS], next_tstep [CHANNELS];
  logic [1:0]               next_wid [CHANNELS];
  logic [CHANNELS-1:0]      next_autoi, next_pend, next_tc;

  logic                     tick, ack, na, done, sel_ok;
  logic [2:0]               win;
  logic [COUNT_BITS-1:0]    step_bytes;

  function automatic logic [31:0] stepped(input logic [31:0] a, input logic [1:0] m,
                                          input logic [COUNT_BITS-1:0] n);
    logic [31:0] d;
    d = 32'(n);
    case (m)
      2'b00:   stepped = a + d;
      2'b01:   stepped = a - d;
      default: stepped = a;
    endcase
  endfunction : stepped

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  always_comb begin
    next_phase       = ~phase;                       // R23
    tick             = phase;                        // R23
    ack              = ~READY_N;                     // R12
    na               = master & ~NEXT_ADDRESS_REQUEST_N; // R25
    next_master      = master;
    next_granted     = granted;
    next_bstate      = bstate;
    next_chan        = chan;
    next_tgt_side    = tgt_side;
    next_address_available        = address_available;
    next_sl_pipe     = sl_pipe;
    next_sl_dec      = 1'b0;
    next_sl_ack_prev = sl_ack_prev;
    next_pend        = pend | SW_REQUEST | CHANNEL_REQUEST; // R18
    next_tc          = tc;
    next_autoi       = autoi;
    win              = 3'h0;
    sel_ok           = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (next_pend[i]) begin
        win    = 3'(i);                              // R20
        sel_ok = 1'b1;
      end
    end
    next_hold_q = hold_q;
    for (int i = 0; i < CHANNELS; i++) begin          // R13
      next_req_base[i] = req_base[i];
      next_tgt_base[i] = tgt_base[i];
      next_req_cur[i]  = req_cur[i];
      next_tgt_cur[i]  = tgt_cur[i];
      next_cnt_base[i] = cnt_base[i];
      next_cnt_cur[i]  = cnt_cur[i];
      next_hold_reg[i] = hold_reg[i];
      next_rstep[i]    = rstep[i];
      next_tstep[i]    = tstep[i];
      next_wid[i]      = wid[i];
    end
    case (wid[chan])                                 // R14
      2'b00:   step_bytes = COUNT_BITS'(1);
      2'b01:   step_bytes = COUNT_BITS'(2);
      default: step_bytes = COUNT_BITS'(4);
    endcase
    done = ~END_OF_PROCESS_N | tc[chan];
    // Setup only while slave; base values only change here
    if (SETUP_WE && !master) begin                   // R18 R15
      next_req_base[SETUP_CHAN] = SETUP_REQ_BASE;
      next_req_cur[SETUP_CHAN]  = SETUP_REQ_BASE;
      next_tgt_base[SETUP_CHAN] = SETUP_TGT_BASE;
      next_tgt_cur[SETUP_CHAN]  = SETUP_TGT_BASE;
      next_cnt_base[SETUP_CHAN] = SETUP_COUNT;
      next_cnt_cur[SETUP_CHAN]  = SETUP_COUNT;
      next_rstep[SETUP_CHAN]    = SETUP_REQ_STEP;
      next_tstep[SETUP_CHAN]    = SETUP_TGT_STEP;
      next_wid[SETUP_CHAN]      = SETUP_WIDTH;
      next_autoi[SETUP_CHAN]    = SETUP_AUTOINIT;
      next_tc[SETUP_CHAN]       = 1'b0;
    end
    if (tick) begin
      if (!master) begin
        next_hold_q = |next_pend;                    // R19 R22
        // Slave: pipelined cycle seen as strobe before prior ack
        next_sl_ack_prev = ack;
        if (!ADDRESS_STROBE_N) begin                 // R11
          next_sl_pipe = ~sl_ack_prev;
          next_sl_dec  = ~sl_ack_prev;
        end else if (sl_pipe | ack) begin
          next_sl_dec  = 1'b1;                       // R11
          next_sl_pipe = 1'b0;
        end
        if (hold_q && HOLD_ACK && sel_ok) begin      // R19 R24
          next_master   = 1'b1;
          next_chan     = win;                       // R20
          // Auto-restart channel would otherwise end at once on its old count
          if (autoi[win]) next_tc[win] = 1'b0;       // R16
          next_bstate   = dmabs_pkg::DMABS_IDLE;     // R1
          next_address_available     = 1'b1;                      // R26
          next_tgt_side = 1'b0;
        end
      end else begin
        unique case (bstate)
          dmabs_pkg::DMABS_IDLE: begin
            if (address_available && !done) next_bstate = dmabs_pkg::DMABS_ADDRESS; // R6
          end
          dmabs_pkg::DMABS_ADDRESS: begin
            next_bstate = dmabs_pkg::DMABS_DATA;     // R2
            next_address_available   = 1'b0;
          end
          dmabs_pkg::DMABS_PIPE_ADDR: begin
            next_address_available = 1'b0;
            if (!na) next_bstate = dmabs_pkg::DMABS_DATA;
            else if (address_available && !done) next_bstate = dmabs_pkg::DMABS_PIPE_DATA; // R5
            else next_bstate = dmabs_pkg::DMABS_PIPE_WAIT; // R9 R10
          end
          dmabs_pkg::DMABS_DATA: begin
            if (ack) begin                           // R12
              if (address_available && !done) next_bstate = dmabs_pkg::DMABS_ADDRESS; // R4
              else next_bstate = dmabs_pkg::DMABS_IDLE;              // R1 R4
            end else if (!na) next_bstate = dmabs_pkg::DMABS_DATA;   // R3
            else if (address_available && !done) next_bstate = dmabs_pkg::DMABS_PIPE_DATA; // R5
            else next_bstate = dmabs_pkg::DMABS_PIPE_WAIT;           // R8 R10
          end
          dmabs_pkg::DMABS_PIPE_WAIT: begin
            if (ack) begin
              if (address_available && !done) next_bstate = dmabs_pkg::DMABS_ADDRESS;
              else next_bstate = dmabs_pkg::DMABS_IDLE;              // R1
            end else if (address_available && !done) next_bstate = dmabs_pkg::DMABS_PIPE_DATA; // R9
          end
          dmabs_pkg::DMABS_PIPE_DATA: begin          // R7
            if (ack) begin                           // R12
              if (na) next_bstate = dmabs_pkg::DMABS_PIPE_ADDR;      // R6
              else next_bstate = dmabs_pkg::DMABS_DATA;
            end
          end
          default: next_bstate = dmabs_pkg::DMABS_IDLE;
        endcase
        // Cycle completion: advance current values, alternate sides
        if (ack && (bstate == dmabs_pkg::DMABS_DATA || bstate == dmabs_pkg::DMABS_PIPE_DATA
            || bstate == dmabs_pkg::DMABS_PIPE_WAIT)) begin
          next_tgt_side = ~tgt_side;
          next_address_available     = 1'b1;                      // R26
          if (!tgt_side) begin
            next_hold_reg[chan] = DATA_IN;           // R17
            next_req_cur[chan]  = stepped(req_cur[chan], rstep[chan], step_bytes); // R15
          end else begin
            next_tgt_cur[chan]  = stepped(tgt_cur[chan], tstep[chan], step_bytes); // R15
            if (cnt_cur[chan] < step_bytes) begin    // R16
              next_tc[chan] = 1'b1;
              next_address_available     = 1'b0;
              if (autoi[chan]) begin
                next_cnt_cur[chan] = cnt_base[chan];
                next_req_cur[chan] = req_base[chan];
                next_tgt_cur[chan] = tgt_base[chan];
              end
            end else begin
              next_cnt_cur[chan] = cnt_cur[chan] - step_bytes; // R16
            end
          end
        end
        // Leave master on completion or lost acknowledge
        if (!HOLD_ACK || (done && next_bstate == dmabs_pkg::DMABS_IDLE)) begin // R21 R22
          next_master = 1'b0;
          next_hold_q = 1'b0;                        // R22
          next_bstate = dmabs_pkg::DMABS_IDLE;
          if (done) next_pend[chan] = CHANNEL_REQUEST[chan];
        end
      end
    end
    next_granted = master;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase <= 1'b0;  master <= 1'b0;  granted <= 1'b0;
      bstate <= dmabs_pkg::DMABS_IDLE;               // R1
      chan <= 3'h0;  tgt_side <= 1'b0;  address_available <= 1'b0;  hold_q <= 1'b0;
      sl_pipe <= 1'b0;  sl_dec <= 1'b0;  sl_ack_prev <= 1'b1;
      autoi <= '0;  pend <= '0;  tc <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        req_base[i] <= dmabs_pkg::ADDR_RESET;  req_cur[i] <= dmabs_pkg::ADDR_RESET;
        tgt_base[i] <= dmabs_pkg::ADDR_RESET;  tgt_cur[i] <= dmabs_pkg::ADDR_RESET;
        hold_reg[i] <= dmabs_pkg::ADDR_RESET;
        cnt_base[i] <= COUNT_BITS'(0);  cnt_cur[i] <= COUNT_BITS'(0);
        rstep[i] <= 2'h0;  tstep[i] <= 2'h0;  wid[i] <= 2'h0;
      end
    end else if (CLK_EN) begin
      phase <= next_phase;  master <= next_master;  granted <= next_granted;
      bstate <= next_bstate;  chan <= next_chan;  tgt_side <= next_tgt_side;
      address_available <= next_address_available;  hold_q <= next_hold_q;
      sl_pipe <= next_sl_pipe;  sl_dec <= next_sl_dec;  sl_ack_prev <= next_sl_ack_prev;
      autoi <= next_autoi;  pend <= next_pend;  tc <= next_tc;
      req_base <= next_req_base;  req_cur <= next_req_cur;
      tgt_base <= next_tgt_base;  tgt_cur <= next_tgt_cur;
      hold_reg <= next_hold_reg;  cnt_base <= next_cnt_base;  cnt_cur <= next_cnt_cur;
      rstep <= next_rstep;  tstep <= next_tstep;  wid <= next_wid;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    HOLD_REQ             = hold_q;                   // R19
    BUS_STATE            = bstate;
    ADDR_OE              = master;
    ADDR_OUT             = tgt_side ? tgt_cur[chan] : req_cur[chan];
    // Strobe only in cycle-start states
    ADDRESS_STROBE_OUT_N = ~(master && (bstate == dmabs_pkg::DMABS_ADDRESS
                           || bstate == dmabs_pkg::DMABS_PIPE_DATA)); // R2 R5
    TARGET_PHASE         = tgt_side;
    ACK_CODE             = (master && !tgt_side) ? chan : dmabs_pkg::ACK_IDLE_CODE;
    HOLDING_OUT          = hold_reg[chan];
    TERMINAL_COUNT       = tc;
    SLAVE_DECODE         = sl_dec;                   // R11
  end

endmodule : dmabs_sequencer

/* verif/dmabs_chk.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module dmabs_chk (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       READY_N,
  input wire logic       NEXT_ADDRESS_REQUEST_N,
  input wire logic       HOLD_ACK,
  input wire logic       HOLD_REQ,
  input wire logic       ADDR_OE,
  input wire logic       ADDRESS_STROBE_OUT_N,
  input wire logic [2:0] BUS_STATE
);
  // ----------------------------------------
  // Bus state and hold handshake properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire st_idle  = BUS_STATE == dmabs_pkg::DMABS_IDLE;
  wire st_addr  = BUS_STATE == dmabs_pkg::DMABS_ADDRESS;
  wire st_data  = BUS_STATE == dmabs_pkg::DMABS_DATA;
  wire st_pdata = BUS_STATE == dmabs_pkg::DMABS_PIPE_DATA;
  AST_RESET_IDLE: assert property ($rose(RST_N) |-> st_idle && !HOLD_REQ && !ADDR_OE)
    else $error("not idle after reset");
  AST_ADDR_THEN_DATA: assert property (st_addr && HOLD_ACK ##1 !st_addr |-> st_data)
    else $error("address state not followed by data state");
  AST_ADDR_STROBE: assert property (st_addr |-> !ADDRESS_STROBE_OUT_N && ADDR_OE)
    else $error("address state without strobe");
  AST_DATA_REPEAT: assert property (st_data && READY_N && NEXT_ADDRESS_REQUEST_N && HOLD_ACK
    |=> st_data)
    else $error("data state left without acknowledge");
  AST_ACK_LEAVES: assert property (st_data && !READY_N && NEXT_ADDRESS_REQUEST_N
    |=> st_data || st_addr || st_idle)
    else $error("bad state after acknowledged data");
  AST_IDLE_EXIT: assert property (st_idle ##1 !st_idle |-> st_addr)
    else $error("first cycle after idle not unpipelined");
  AST_PIPE_STRETCH: assert property (st_pdata && READY_N && HOLD_ACK |=> st_pdata)
    else $error("pipelined cycle not lengthened");
  AST_STATE_TWO: assert property ($changed(BUS_STATE) |=> $stable(BUS_STATE))
    else $error("bus state shorter than two clocks");
  AST_MASTER_AFTER_ACK: assert property ($rose(ADDR_OE) |-> $past(HOLD_ACK) && HOLD_REQ)
    else $error("bus driven without hold acknowledge");
  AST_RELEASE_BUS: assert property (ADDR_OE && !HOLD_ACK |-> ##[0:40] !ADDR_OE)
    else $error("bus kept after hold acknowledge dropped");
  COV_PIPE: cover property (st_pdata);
  COV_PIPE_WAIT: cover property (BUS_STATE == dmabs_pkg::DMABS_PIPE_WAIT);
  COV_HOLD: cover property ($rose(HOLD_REQ));
endmodule : dmabs_chk

bind dmabs_sequencer dmabs_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .READY_N(READY_N), .HOLD_ACK(HOLD_ACK), .HOLD_REQ(HOLD_REQ),
  .NEXT_ADDRESS_REQUEST_N(NEXT_ADDRESS_REQUEST_N), .ADDR_OE(ADDR_OE),
  .ADDRESS_STROBE_OUT_N(ADDRESS_STROBE_OUT_N), .BUS_STATE(BUS_STATE)
);

/* verif/dmabs_host_model.sv */
// Host processor and local-bus memory model
`timescale 1ns/1ps
module dmabs_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        grant_en,
  input  wire logic        pipe_en,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        hold_req,
  input  wire logic [2:0]  bus_state,
  input  wire logic [31:0] addr_out,
  output logic             hold_ack,
  output logic             ready_n,
  output logic             next_address_request_n,
  output logic [31:0]      data_in
);
  logic [3:0]  waited;
  logic [2:0]  seen;
  logic [31:0] noise;
  wire in_data = bus_state == dmabs_pkg::DMABS_DATA || bus_state == dmabs_pkg::DMABS_PIPE_DATA;
  // Data valid only with acknowledge; lines churn otherwise
  assign data_in = ready_n ? noise : addr_out ^ 32'h5A5A5A5A;
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ack <= 1'b0;
      ready_n <= 1'b1;
      next_address_request_n <= 1'b1;
      waited <= 4'h0;
      seen <= 3'h0;
      noise <= 32'h0;
    end else begin
      hold_ack <= hold_req && grant_en;
      waited <= (bus_state != seen) ? 4'h0 : waited + {3'h0, waited != 4'hF};
      seen <= bus_state;
      // Held low until the state moves on, so a decision edge sees it
      ready_n <= !(in_data && bus_state == seen && waited >= wait_cycles);
      next_address_request_n <= !pipe_en;
      noise <= ~noise;
    end
  end
endmodule : dmabs_host_model

/* verif/tb.sv */
// Self-checking bench for the bus-master sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb;
  logic        clk, rst_n, setup_we, autoinit, hold_ack, ready_n, na_n, eop_n, grant_en;
  logic        pipe_en, slv_n, strobe_wire, hold_req, addr_oe, strobe_out_n, tgt_ph, sdec;
  logic [1:0]  req_step, tgt_step, width;
  logic [2:0]  chan, ack_code, bus_state, prev;
  logic [3:0]  wait_cycles;
  logic [7:0]  sw_req, chan_req, tc;
  logic [23:0] count;
  logic [31:0] req_base, tgt_base, data_in, addr_out;
  logic [31:0] req_q[$], tgt_q[$];
  logic [2:0]  ack_q[$];
  int          bad_count, check_count;
  // Released strobe line is driven by the bench from slv_n
  assign strobe_wire = addr_oe ? strobe_out_n : slv_n;
  dmabs_sequencer DUT (
    .CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .SETUP_WE(setup_we), .SETUP_CHAN(chan),
    .SETUP_REQ_BASE(req_base), .SETUP_TGT_BASE(tgt_base), .SETUP_COUNT(count),
    .SETUP_REQ_STEP(req_step), .SETUP_TGT_STEP(tgt_step), .SETUP_WIDTH(width),
    .SETUP_AUTOINIT(autoinit), .SW_REQUEST(sw_req), .CHANNEL_REQUEST(chan_req),
    .HOLD_ACK(hold_ack), .HOLD_REQ(hold_req), .READY_N(ready_n), .NEXT_ADDRESS_REQUEST_N(na_n),
    .ADDRESS_STROBE_N(strobe_wire), .END_OF_PROCESS_N(eop_n), .DATA_IN(data_in),
    .ADDR_OUT(addr_out), .ADDR_OE(addr_oe), .ADDRESS_STROBE_OUT_N(strobe_out_n),
    .TARGET_PHASE(tgt_ph), .ACK_CODE(ack_code), .HOLDING_OUT(), .TERMINAL_COUNT(tc),
    .SLAVE_DECODE(sdec), .BUS_STATE(bus_state));
  dmabs_host_model host (
    .clk(clk), .rst_n(rst_n), .grant_en(grant_en), .pipe_en(pipe_en), .wait_cycles(wait_cycles),
    .hold_req(hold_req), .bus_state(bus_state), .addr_out(addr_out), .hold_ack(hold_ack),
    .ready_n(ready_n), .next_address_request_n(na_n), .data_in(data_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Logs each newly strobed address, split by access side
  always @(posedge clk) begin
    if (addr_oe === 1'b1 && strobe_out_n === 1'b0 && bus_state !== prev) begin
      if (tgt_ph === 1'b1) tgt_q.push_back(addr_out);
      else begin
        req_q.push_back(addr_out);
        ack_q.push_back(ack_code);
      end
    end
    prev = bus_state;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic setup(input logic [2:0] ch, input logic [31:0] rb, tgb,
                       input logic [23:0] n, input logic [1:0] rs, ts, w, input logic ai);
    {chan, req_base, tgt_base, count} = {ch, rb, tgb, n};
    {req_step, tgt_step, width, autoinit, setup_we} = {rs, ts, w, ai, 1'b1};
    repeat (2) @(negedge clk);
    setup_we = 1'b0;
    req_q.delete();
    tgt_q.delete();
    ack_q.delete();
  endtask : setup
  task automatic kick(input logic [7:0] hw, sw);
    {chan_req, sw_req} = {hw, sw};
    repeat (2) @(negedge clk);
    {chan_req, sw_req} = 16'h0000;
  endtask : kick
  task automatic hold_wait(input logic v);
    for (int i = 0; i < 600 && hold_req !== v; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : hold_wait
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_idle();
    `CHK("bus_state", dmabs_pkg::DMABS_IDLE, bus_state)
    `CHK("ack_code", dmabs_pkg::ACK_IDLE_CODE, ack_code)
    pipe_en = 1'b1;
    slv_n = 1'b0;
    for (int i = 0; i < 8 && sdec !== 1'b1; i++) @(negedge clk);
    `CHK("slave_decode", 1'b1, sdec)
    slv_n = 1'b1;
    `CHK("hold_req", 1'b0, hold_req)
    pipe_en = 1'b0;
    $display("test idle done");
  endtask : t_idle
  task automatic t_transfer();
    wait_cycles = 4'h2;
    setup(3'h2, 32'h00000100, 32'h00000200, 24'h000003, 2'h0, 2'h1, 2'h0, 1'b0);
    kick(8'h04, 8'h00);
    hold_wait(1'b1);
    `CHK("hold_req", 1'b1, hold_req)
    hold_wait(1'b0);
    `CHK("tc2", 1'b1, tc[2])
    `CHK("addr_oe", 1'b0, addr_oe)
    `CHK("req0", 32'h00000100, req_q[0])
    `CHK("req1", 32'h00000101, req_q[1])
    `CHK("tgt1", 32'h000001FF, tgt_q[1])
    `CHK("ack0", 3'h2, ack_q[0])
    $display("test transfer done");
  endtask : t_transfer
  task automatic t_priority();
    grant_en = 1'b0;
    setup(3'h5, 32'h00000500, 32'h00000600, 24'h000001, 2'h0, 2'h2, 2'h0, 1'b0);
    setup(3'h1, 32'h00000110, 32'h00000610, 24'h000002, 2'h1, 2'h0, 2'h1, 1'b0);
    kick(8'h00, 8'h20);
    hold_wait(1'b1);
    kick(8'h02, 8'h00);
    grant_en = 1'b1;
    for (int i = 0; i < 900 && !(ack_q.size() > 0 && ack_q[$] === 3'h5); i++) @(negedge clk);
    `CHK("first", 3'h1, ack_q[0])
    `CHK("later", 3'h5, ack_q[$])
    hold_wait(1'b0);
    $display("test priority done");
  endtask : t_priority
  task automatic t_pipe();
    pipe_en = 1'b1;
    wait_cycles = 4'h0;
    setup(3'h3, 32'h00001000, 32'h00002000, 24'h000004, 2'h0, 2'h2, 2'h2, 1'b1);
    repeat (2) begin
      req_q.delete();
      kick(8'h08, 8'h00);
      hold_wait(1'b1);
      hold_wait(1'b0);
      `CHK("base", 32'h00001000, req_q[0])
    end
    `CHK("tc3", 1'b1, tc[3])
    pipe_en = 1'b0;
    $display("test pipe done");
  endtask : t_pipe
  task automatic t_eop();
    wait_cycles = 4'h1;
    setup(3'h0, 32'h00003000, 32'h00004000, 24'h0000FF, 2'h0, 2'h0, 2'h0, 1'b0);
    kick(8'h01, 8'h00);
    for (int i = 0; i < 64 && addr_oe !== 1'b1; i++) @(negedge clk);
    grant_en = 1'b0;
    for (int i = 0; i < 64 && addr_oe !== 1'b0; i++) @(negedge clk);
    `CHK("addr_oe", 1'b0, addr_oe)
    grant_en = 1'b1;
    repeat (20) @(negedge clk);
    eop_n = 1'b0;
    hold_wait(1'b0);
    eop_n = 1'b1;
    `CHK("hold_req", 1'b0, hold_req)
    `CHK("tc0", 1'b0, tc[0])
    $display("test eop done");
  endtask : t_eop
  initial begin
    {rst_n, setup_we, autoinit, grant_en, pipe_en, slv_n, eop_n} = 7'b0001011;
    {chan, req_base, tgt_base, count, req_step, tgt_step, width} = '0;
    {sw_req, chan_req, wait_cycles} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_idle();
    t_transfer();
    t_priority();
    t_pipe();
    t_eop();
    summarize();
  end
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule : tb
